// file: hw/pci_bridge_queue_cmd_path.sv
// Queue structure and command handling for both directions of a transparent bus bridge.
`timescale 1ns/100ps
module pci_bridge_queue_cmd_path (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [1:0] tgt_start_i,
  input wire logic [1:0][3:0] tgt_cmd_i,
  input wire logic [1:0][31:0] tgt_addr_i,
  input wire logic [1:0] tgt_type1_i,
  input wire logic [1:0] tgt_hit_i,
  input wire logic [1:0] tgt_par_i,
  input wire logic [1:0][3:0] tgt_be_i,
  input wire logic [1:0][31:0] tgt_wdata_i,
  input wire logic [1:0] tgt_wvalid_i,
  input wire logic [1:0] tgt_last_i,
  input wire logic [1:0] tgt_rready_i,
  output logic [1:0] tgt_devsel_o,
  output logic [1:0] tgt_retry_o,
  output logic [1:0] tgt_disc_o,
  output logic [1:0] tgt_wready_o,
  output logic [1:0] tgt_rvalid_o,
  output logic [1:0][31:0] tgt_rdata_o,
  output logic [1:0] tgt_done_o,
  output logic [1:0][1:0] tgt_status_o,
  output logic [1:0] mst_pw_valid_o,
  output logic [1:0][bridge_pkg::PWW-1:0] mst_pw_data_o,
  input wire logic [1:0] mst_pw_ready_i,
  output logic [1:0] mst_dt_valid_o,
  input wire logic [1:0] mst_dt_ready_i,
  output logic [1:0][31:0] mst_dt_addr_o,
  output logic [1:0][31:0] mst_dt_hi_o,
  output logic [1:0] mst_dt_dual_o,
  output logic [1:0][3:0] mst_dt_cmd_o,
  output logic [1:0][3:0] mst_dt_be_o,
  output logic [1:0][31:0] mst_dt_wdata_o,
  output logic [1:0] mst_dt_par_o,
  output logic [1:0] mst_dt_type1_o,
  input wire logic [1:0] mst_cpl_valid_i,
  input wire logic [1:0][1:0] mst_cpl_status_i,
  input wire logic [1:0] mst_rd_valid_i,
  input wire logic [1:0] mst_rd_last_i,
  input wire logic [1:0][31:0] mst_rd_data_i,
  output logic [1:0] mst_rd_ready_o
);
  import bridge_pkg::*;

  // Index 0 is the downstream path (primary initiator), index 1 the upstream path.
  for (genvar d = 0; d < 2; d++) begin : g_dir
    localparam logic SEC = (d == 1);
    tstate_t st;
    tstate_t next_st;
    logic [3:0] cmd;
    logic [31:0] addr;
    logic [31:0] addr_hi;
    logic dual;
    logic type1;
    logic par;
    logic hi_pend;
    logic lin;
    logic acc;
    logic room;
    logic match;
    logic ev_claim;
    logic ev_retry;
    logic ev_disc;
    logic ev_done;
    logic dt_push;
    logic dt_pop;
    logic rd_pop;
    logic pw_v;
    logic pw_rdy;
    pw_word_t pw_d;
    pw_word_t pw_out;
    logic [FREE_W-1:0] pw_free;
    rd_word_t rd_d;
    logic rd_v;
    dt_ent_t dt_new;
    dt_ent_t dt_head;
    dt_ent_t dt_iss;
    logic dt_full;
    logic dt_head_v;
    logic dt_head_done;
    logic [1:0] dt_head_st;
    logic dt_iss_v;
    logic devsel;

    assign lin = addr[1:0] == LIN_BITS;
    assign acc = tgt_hit_i[d] && may_accept(cmd, SEC, type1);
    assign room = pw_free >= (PW_CLAIM_FREE + FREE_W'(dual));
    assign match = dt_head_v && dt_head.cmd == cmd && dt_head.addr == addr && dt_head.hi == addr_hi
                   && dt_head.dual == dual;
    assign dt_new = '{type1: type1, dual: dual, hi: addr_hi, addr: addr, cmd: cmd,
                      be: is_prefetch(cmd) ? BE_NONE : tgt_be_i[d],
                      wdata: tgt_wdata_i[d], par: par};

    always_comb begin
      next_st = st;
      ev_claim = 1'b0;
      ev_retry = 1'b0;
      ev_disc = 1'b0;
      ev_done = 1'b0;
      dt_push = 1'b0;
      dt_pop = 1'b0;
      rd_pop = 1'b0;
      pw_v = 1'b0;
      pw_d = '{is_addr: 1'b1, cbe: dual ? C_DAC : cmd, data: addr};
      unique case (st)
        S_IDLE: begin
          if (tgt_start_i[d]) begin
            next_st = (tgt_cmd_i[d] == C_DAC) ? S_DAC : S_DEC;
          end
        end
        S_DAC: begin
          next_st = S_DEC;
        end
        S_DEC: begin
          if (!acc) begin
            next_st = S_IDLE;
          end else if (is_posted(cmd)) begin
            if (room) begin
              ev_claim = 1'b1;
              pw_v = 1'b1;
              next_st = S_PW;
            end else begin
              ev_retry = 1'b1;
              next_st = S_IDLE;
            end
          end else if (match && dt_head_done) begin
            ev_claim = 1'b1;
            if (is_dwrite(cmd)) begin
              ev_done = 1'b1;
              dt_pop = 1'b1;
              next_st = S_IDLE;
            end else begin
              next_st = S_RD;
            end
          end else if (match || dt_full) begin
            ev_retry = 1'b1;
            next_st = S_IDLE;
          end else if (!is_dwrite(cmd) || tgt_wvalid_i[d]) begin
            dt_push = 1'b1;
            ev_retry = 1'b1;
            next_st = S_IDLE;
          end
        end
        S_PW: begin
          if (hi_pend) begin
            pw_v = 1'b1;
            pw_d = '{is_addr: 1'b1, cbe: cmd, data: addr_hi};
          end else if (tgt_wvalid_i[d]) begin
            pw_v = 1'b1;
            pw_d = '{is_addr: 1'b0, cbe: tgt_be_i[d], data: tgt_wdata_i[d]};
            if (pw_rdy) begin
              if (tgt_last_i[d]) begin
                next_st = S_IDLE;
              end else if (!lin || pw_free == PW_LAST_FREE) begin
                ev_disc = 1'b1;
                next_st = S_IDLE;
              end
            end
          end
        end
        S_RD: begin
          if (rd_v && tgt_rready_i[d]) begin
            rd_pop = 1'b1;
            if (rd_d.last || tgt_last_i[d] || !lin) begin
              ev_disc = !tgt_last_i[d];
              ev_done = 1'b1;
              dt_pop = 1'b1;
              next_st = rd_d.last ? S_IDLE : S_DROP;
            end
          end
        end
        S_DROP: begin
          rd_pop = rd_v;
          if (rd_v && rd_d.last) begin
            next_st = S_IDLE;
          end
        end
      endcase
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
        st <= S_IDLE;
      end else begin
        st <= next_st;
      end
    end

    // The first phase carries the low address; a dual cycle's second phase carries command and high address.
    always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
        cmd <= C_INTA;
        addr <= '0;
        addr_hi <= '0;
        dual <= 1'b0;
        type1 <= 1'b0;
        par <= 1'b0;
      end else if (st == S_IDLE && tgt_start_i[d]) begin
        cmd <= tgt_cmd_i[d];
        addr <= tgt_addr_i[d];
        addr_hi <= '0;
        dual <= 1'b0;
        type1 <= tgt_type1_i[d];
        par <= tgt_par_i[d];
      end else if (st == S_DAC) begin
        cmd <= tgt_cmd_i[d];
        addr_hi <= tgt_addr_i[d];
        dual <= 1'b1;
      end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
        hi_pend <= 1'b0;
      end else if (st == S_DEC) begin
        hi_pend <= ev_claim && is_posted(cmd) && dual;
      end else if (pw_rdy) begin
        hi_pend <= 1'b0;
      end
    end

    // Select is driven the clock after decode, which is medium timing.
    always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
        devsel <= 1'b0;
        tgt_retry_o[d] <= 1'b0;
        tgt_disc_o[d] <= 1'b0;
        tgt_done_o[d] <= 1'b0;
        tgt_status_o[d] <= 2'h0;
      end else begin
        devsel <= ev_claim || (devsel && st != S_IDLE && next_st != S_IDLE);
        tgt_retry_o[d] <= ev_retry;
        tgt_disc_o[d] <= ev_disc;
        tgt_done_o[d] <= ev_done;
        if (ev_done) begin
          tgt_status_o[d] <= dt_head_st;
        end
      end
    end

    assign tgt_devsel_o[d] = devsel;
    assign tgt_wready_o[d] = st == S_PW && !hi_pend && pw_rdy;
    assign tgt_rvalid_o[d] = st == S_RD && rd_v;
    assign tgt_rdata_o[d] = rd_d.data;

    bridge_fifo #(.W(PWW), .D(PW_DEPTH)) u_pwq (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .in_valid_i(pw_v),
      .in_ready_o(pw_rdy),
      .in_data_i(pw_d),
      .out_valid_o(mst_pw_valid_o[d]),
      .out_ready_i(mst_pw_ready_i[d]),
      .out_data_o(pw_out),
      .free_o(pw_free)
    );
    assign mst_pw_data_o[d] = pw_out;

    bridge_fifo #(.W(RDW), .D(RD_DEPTH)) u_rdq (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .in_valid_i(mst_rd_valid_i[d]),
      .in_ready_o(mst_rd_ready_o[d]),
      .in_data_i({mst_rd_last_i[d], mst_rd_data_i[d]}),
      .out_valid_o(rd_v),
      .out_ready_i(rd_pop),
      .out_data_o(rd_d),
      .free_o()
    );

    bridge_dtq u_dtq (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .push_i(dt_push),
      .push_d_i(dt_new),
      .full_o(dt_full),
      .head_v_o(dt_head_v),
      .head_done_o(dt_head_done),
      .head_st_o(dt_head_st),
      .head_d_o(dt_head),
      .iss_v_o(dt_iss_v),
      .iss_d_o(dt_iss),
      .iss_i(mst_dt_valid_o[d] && mst_dt_ready_i[d]),
      .cpl_i(mst_cpl_valid_i[d]),
      .cpl_st_i(mst_cpl_status_i[d]),
      .pop_i(dt_pop)
    );

    // A delayed request waits until every posted write queued before it has left.
    assign mst_dt_valid_o[d] = dt_iss_v && !mst_pw_valid_o[d] && !pw_v;
    assign mst_dt_addr_o[d] = dt_iss.addr;
    assign mst_dt_hi_o[d] = dt_iss.hi;
    assign mst_dt_dual_o[d] = dt_iss.dual;
    assign mst_dt_cmd_o[d] = dt_iss.cmd;
    assign mst_dt_be_o[d] = dt_iss.be;
    assign mst_dt_wdata_o[d] = dt_iss.wdata;
    assign mst_dt_par_o[d] = dt_iss.par;
    assign mst_dt_type1_o[d] = dt_iss.type1;

    a_resv_ignored: assert property (@(posedge mclk_i) disable iff (reset_i)
      st == S_DEC && (cmd == C_RSV4 || cmd == C_RSV5 || cmd == C_RSV8 || cmd == C_RSV9)
      |=> !tgt_devsel_o[d] && !tgt_retry_o[d] && st == S_IDLE)
      else $error("reserved command was answered");
    a_intack_ignored: assert property (@(posedge mclk_i) disable iff (reset_i)
      st == S_DEC && cmd == C_INTA |=> !tgt_devsel_o[d] && !tgt_retry_o[d])
      else $error("interrupt acknowledge was answered");
    a_special_ignored: assert property (@(posedge mclk_i) disable iff (reset_i)
      st == S_DEC && cmd == C_SPEC |=> !tgt_devsel_o[d] && !tgt_retry_o[d])
      else $error("special cycle was answered");
    a_type0_secondary: assert property (@(posedge mclk_i) disable iff (reset_i)
      SEC && st == S_DEC && (cmd == C_CFRD || (cmd == C_CFWR && !type1)) |=> !tgt_devsel_o[d] && !tgt_retry_o[d])
      else $error("secondary configuration cycle was claimed");
    a_issue_legal: assert property (@(posedge mclk_i) disable iff (reset_i)
      mst_dt_valid_o[d] |-> may_initiate(mst_dt_cmd_o[d], !SEC, mst_dt_type1_o[d]))
      else $error("illegal command offered as master");
    a_dac_second: assert property (@(posedge mclk_i) disable iff (reset_i)
      st == S_IDLE && tgt_start_i[d] && tgt_cmd_i[d] == C_DAC |=> st == S_DAC ##1 st == S_DEC && dual)
      else $error("dual address phase not taken on next clock");
    a_pw_room_retry: assert property (@(posedge mclk_i) disable iff (reset_i)
      st == S_DEC && acc && is_posted(cmd) && pw_free < PW_CLAIM_FREE |=> tgt_retry_o[d] && !tgt_devsel_o[d])
      else $error("memory write claimed without room");
    a_nonlin_disc: assert property (@(posedge mclk_i) disable iff (reset_i)
      tgt_wready_o[d] && tgt_wvalid_i[d] && !lin && !tgt_last_i[d] |=> tgt_disc_o[d] ##1 !tgt_devsel_o[d])
      else $error("non-linear burst not disconnected");
    a_dt_full_retry: assert property (@(posedge mclk_i) disable iff (reset_i)
      st == S_DEC && acc && !is_posted(cmd) && !match && dt_full |=> tgt_retry_o[d] && $stable(dt_full))
      else $error("full delayed queue did not retry");
    a_posted_first: assert property (@(posedge mclk_i) disable iff (reset_i)
      mst_pw_valid_o[d] |-> !mst_dt_valid_o[d])
      else $error("delayed request passed a posted write");
    c_posted_claim: cover property (@(posedge mclk_i) disable iff (reset_i)
      st == S_DEC && ev_claim && is_posted(cmd) ##1 tgt_wready_o[d]);
    c_delayed_retry: cover property (@(posedge mclk_i) disable iff (reset_i) st == S_DEC && dt_push);
    c_read_deliver: cover property (@(posedge mclk_i) disable iff (reset_i)
      tgt_rvalid_o[d] && tgt_rready_i[d] ##[1:40] tgt_done_o[d]);
  end
endmodule : pci_bridge_queue_cmd_path

// file: hw/bridge_pkg.sv
// Shared constants, types and command decode functions for the bridge queue and command path.
package bridge_pkg;
  localparam int DWORD_W = 32;
  localparam int PW_DEPTH = 32;
  localparam int RD_DEPTH = 32;
  localparam int DT_DEPTH = 4;
  localparam int FREE_W = 6;
  localparam logic [FREE_W-1:0] PW_CLAIM_FREE = 6'h09;
  localparam logic [FREE_W-1:0] PW_LAST_FREE = 6'h01;
  localparam logic [3:0] BE_NONE = 4'h0;
  localparam logic [1:0] LIN_BITS = 2'h0;
  localparam logic [3:0] C_INTA = 4'h0;
  localparam logic [3:0] C_SPEC = 4'h1;
  localparam logic [3:0] C_IORD = 4'h2;
  localparam logic [3:0] C_IOWR = 4'h3;
  localparam logic [3:0] C_RSV4 = 4'h4;
  localparam logic [3:0] C_RSV5 = 4'h5;
  localparam logic [3:0] C_MRD = 4'h6;
  localparam logic [3:0] C_MWR = 4'h7;
  localparam logic [3:0] C_RSV8 = 4'h8;
  localparam logic [3:0] C_RSV9 = 4'h9;
  localparam logic [3:0] C_CFRD = 4'hA;
  localparam logic [3:0] C_CFWR = 4'hB;
  localparam logic [3:0] C_MRM = 4'hC;
  localparam logic [3:0] C_DAC = 4'hD;
  localparam logic [3:0] C_MRL = 4'hE;
  localparam logic [3:0] C_MWI = 4'hF;

  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_DAC = 6'b000010,
    S_DEC = 6'b000100,
    S_PW = 6'b001000,
    S_RD = 6'b010000,
    S_DROP = 6'b100000
  } tstate_t;

  typedef struct packed {
    logic type1;
    logic dual;
    logic [DWORD_W-1:0] hi;
    logic [DWORD_W-1:0] addr;
    logic [3:0] cmd;
    logic [3:0] be;
    logic [DWORD_W-1:0] wdata;
    logic par;
  } dt_ent_t;

  typedef struct packed {
    logic is_addr;
    logic [3:0] cbe;
    logic [DWORD_W-1:0] data;
  } pw_word_t;

  typedef struct packed {
    logic last;
    logic [DWORD_W-1:0] data;
  } rd_word_t;

  localparam int PWW = $bits(pw_word_t);
  localparam int RDW = $bits(rd_word_t);

  // Target acceptance; sec is high for the secondary bus.
  function automatic logic may_accept(input logic [3:0] c, input logic sec, input logic t1);
    unique case (c)
      C_INTA, C_SPEC, C_RSV4, C_RSV5, C_RSV8, C_RSV9: may_accept = 1'b0;
      C_CFRD: may_accept = !sec;
      C_CFWR: may_accept = !sec || t1;
      default: may_accept = 1'b1;
    endcase
  endfunction : may_accept

  // Master initiation; sec is high when the target bus is the secondary bus.
  function automatic logic may_initiate(input logic [3:0] c, input logic sec, input logic t1);
    unique case (c)
      C_INTA, C_RSV4, C_RSV5, C_RSV8, C_RSV9: may_initiate = 1'b0;
      C_CFRD: may_initiate = sec;
      C_CFWR: may_initiate = sec || t1;
      default: may_initiate = 1'b1;
    endcase
  endfunction : may_initiate

  function automatic logic is_posted(input logic [3:0] c);
    is_posted = (c == C_MWR) || (c == C_MWI);
  endfunction : is_posted

  function automatic logic is_dwrite(input logic [3:0] c);
    is_dwrite = (c == C_IOWR) || (c == C_CFWR);
  endfunction : is_dwrite

  function automatic logic is_prefetch(input logic [3:0] c);
    is_prefetch = (c == C_MRM) || (c == C_MRL);
  endfunction : is_prefetch
endpackage : bridge_pkg

// file: hw/bridge_fifo.sv
// Parameterised synchronous FIFO with valid and ready on both sides and a free-space count.
`timescale 1ns/100ps
module bridge_fifo #(
  parameter int W = 32,
  parameter int D = 16,
  parameter int AW = $clog2(D)
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o,
  output logic [AW:0] free_o
);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  logic wr;
  logic rd;

  assign wr = in_valid_i && in_ready_o;
  assign rd = out_valid_o && out_ready_i;
  assign in_ready_o = cnt != (AW+1)'(D);
  assign out_valid_o = cnt != '0;
  assign out_data_o = mem[rp];
  assign free_o = (AW+1)'(D) - cnt;

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (wr) begin
        wp <= wp + AW'(1);
      end
      if (rd) begin
        rp <= rp + AW'(1);
      end
      cnt <= cnt + (AW+1)'(wr) - (AW+1)'(rd);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (wr) begin
      mem[wp] <= in_data_i;
    end
  end
endmodule : bridge_fifo

// file: hw/bridge_dtq.sv
// In-order delayed transaction queue with separate issue, completion and head pointers.
`timescale 1ns/100ps
module bridge_dtq (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic push_i,
  input bridge_pkg::dt_ent_t push_d_i,
  output logic full_o,
  output logic head_v_o,
  output logic head_done_o,
  output logic [1:0] head_st_o,
  output bridge_pkg::dt_ent_t head_d_o,
  output logic iss_v_o,
  output bridge_pkg::dt_ent_t iss_d_o,
  input wire logic iss_i,
  input wire logic cpl_i,
  input wire logic [1:0] cpl_st_i,
  input wire logic pop_i
);
  import bridge_pkg::*;
  dt_ent_t mem [DT_DEPTH];
  logic [1:0] st [DT_DEPTH];
  logic [DT_DEPTH-1:0] done;
  logic [2:0] hp;
  logic [2:0] ip;
  logic [2:0] cp;
  logic [2:0] wp;
  logic cpl_ok;

  assign full_o = (wp - hp) == 3'h4;
  assign head_v_o = hp != wp;
  assign iss_v_o = ip != wp;
  assign cpl_ok = cpl_i && (cp != ip);
  assign head_done_o = head_v_o && done[hp[1:0]];
  assign head_st_o = st[hp[1:0]];
  assign head_d_o = mem[hp[1:0]];
  assign iss_d_o = mem[ip[1:0]];

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      wp <= 3'h0;
      ip <= 3'h0;
      cp <= 3'h0;
      hp <= 3'h0;
    end else begin
      if (push_i && !full_o) begin
        wp <= wp + 3'h1;
      end
      if (iss_i && iss_v_o) begin
        ip <= ip + 3'h1;
      end
      if (cpl_ok) begin
        cp <= cp + 3'h1;
      end
      if (pop_i && head_v_o) begin
        hp <= hp + 3'h1;
      end
    end
  end

  // Completion status joins the entry that was issued first.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      done <= '0;
      for (int i = 0; i < DT_DEPTH; i++) begin
        st[i] <= 2'h0;
      end
    end else begin
      if (push_i && !full_o) begin
        done[wp[1:0]] <= 1'b0;
      end
      if (cpl_ok) begin
        done[cp[1:0]] <= 1'b1;
        st[cp[1:0]] <= cpl_st_i;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (push_i && !full_o) begin
      mem[wp[1:0]] <= push_d_i;
    end
  end
endmodule : bridge_dtq

// file: tb/bus_partner.sv
// Far-side bus model that drains posted words and answers delayed requests.
`timescale 1ns/100ps
module bus_partner (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic pw_valid_i,
  input wire logic [bridge_pkg::PWW-1:0] pw_data_i,
  output logic pw_ready_o,
  input wire logic dt_valid_i,
  output logic dt_ready_o,
  input wire logic [31:0] dt_addr_i,
  input wire logic [3:0] dt_cmd_i,
  output logic cpl_valid_o,
  output logic [1:0] cpl_status_o,
  output logic rd_valid_o,
  output logic rd_last_o,
  output logic [31:0] rd_data_o,
  input wire logic rd_ready_i
);
  import bridge_pkg::*;
  logic [PWW-1:0] pw_q[$];
  logic [31:0] a;
  logic [3:0] c;
  int i;
  // Ready toggles every cycle so the posted stream always meets stalls.
  always @(negedge mclk_i) pw_ready_o <= !reset_i && !pw_ready_o;
  always @(posedge mclk_i) if (pw_valid_i && pw_ready_o) pw_q.push_back(pw_data_i);
  initial begin
    {pw_ready_o, dt_ready_o, cpl_valid_o, cpl_status_o, rd_valid_o, rd_last_o, rd_data_o} = '0;
    forever begin
      @(negedge mclk_i);
      if (dt_valid_i && !reset_i) begin
        dt_ready_o = 1'b1;
        @(posedge mclk_i);
        a = dt_addr_i;
        c = dt_cmd_i;
        @(negedge mclk_i);
        dt_ready_o = 1'b0;
        if (c != C_IOWR && c != C_CFWR) begin
          for (i = 0; i < 2; i++) begin
            rd_valid_o = 1'b1;
            rd_last_o = (i == 1);
            rd_data_o = a + 32'(4 * i);
            do @(posedge mclk_i); while (!rd_ready_i);
            @(negedge mclk_i);
          end
          rd_valid_o = 1'b0;
          rd_last_o = 1'b0;
          rd_data_o = ~rd_data_o;
        end
        cpl_status_o = a[5:4];
        cpl_valid_o = 1'b1;
        @(negedge mclk_i);
        cpl_valid_o = 1'b0;
      end
    end
  end
endmodule : bus_partner

// file: tb/testbench.sv
// Self-checking bench for the bridge queue and command path.
`timescale 1ns/100ps
module testbench;
  import bridge_pkg::*;
  logic mclk_i, reset_i;
  logic [1:0] tgt_start_i, tgt_type1_i, tgt_hit_i, tgt_par_i, tgt_wvalid_i, tgt_last_i, tgt_rready_i;
  logic [1:0] tgt_devsel_o, tgt_retry_o, tgt_disc_o, tgt_wready_o, tgt_rvalid_o, tgt_done_o;
  logic [1:0] mst_pw_valid_o, mst_pw_ready_i, mst_dt_valid_o, mst_dt_ready_i, mst_dt_dual_o, mst_dt_par_o;
  logic [1:0] mst_dt_type1_o, mst_cpl_valid_i, mst_rd_valid_i, mst_rd_last_i, mst_rd_ready_o;
  logic [1:0][3:0] tgt_cmd_i, tgt_be_i, mst_dt_cmd_o, mst_dt_be_o;
  logic [1:0][31:0] tgt_addr_i, tgt_wdata_i, tgt_rdata_o, mst_dt_addr_o, mst_dt_hi_o, mst_dt_wdata_o, mst_rd_data_i;
  logic [1:0][1:0] tgt_status_o, mst_cpl_status_i;
  logic [1:0][PWW-1:0] mst_pw_data_o;
  logic [PWW-1:0] exp_q[2][$];
  logic [3:0] bad[6] = '{C_INTA, C_SPEC, C_RSV4, C_RSV5, C_RSV8, C_RSV9};
  logic [31:0] rnd;
  logic [1:0] r;
  int fails, checks_done, d;
  pci_bridge_queue_cmd_path i_pci_bridge_queue_cmd_path (.mclk_i, .reset_i, .tgt_start_i, .tgt_cmd_i,
    .tgt_addr_i, .tgt_type1_i, .tgt_hit_i, .tgt_par_i, .tgt_be_i, .tgt_wdata_i, .tgt_wvalid_i, .tgt_last_i,
    .tgt_rready_i, .tgt_devsel_o, .tgt_retry_o, .tgt_disc_o, .tgt_wready_o, .tgt_rvalid_o, .tgt_rdata_o,
    .tgt_done_o, .tgt_status_o, .mst_pw_valid_o, .mst_pw_data_o, .mst_pw_ready_i, .mst_dt_valid_o,
    .mst_dt_ready_i, .mst_dt_addr_o, .mst_dt_hi_o, .mst_dt_dual_o, .mst_dt_cmd_o, .mst_dt_be_o, .mst_dt_wdata_o,
    .mst_dt_par_o, .mst_dt_type1_o, .mst_cpl_valid_i, .mst_cpl_status_i, .mst_rd_valid_i, .mst_rd_last_i,
    .mst_rd_data_i, .mst_rd_ready_o);
  for (genvar g = 0; g < 2; g++) begin : gp
    bus_partner p (.mclk_i, .reset_i, .pw_valid_i(mst_pw_valid_o[g]), .pw_data_i(mst_pw_data_o[g]),
      .pw_ready_o(mst_pw_ready_i[g]), .dt_valid_i(mst_dt_valid_o[g]), .dt_ready_o(mst_dt_ready_i[g]),
      .dt_addr_i(mst_dt_addr_o[g]), .dt_cmd_i(mst_dt_cmd_o[g]), .cpl_valid_o(mst_cpl_valid_i[g]),
      .cpl_status_o(mst_cpl_status_i[g]), .rd_valid_o(mst_rd_valid_i[g]), .rd_last_o(mst_rd_last_i[g]),
      .rd_data_o(mst_rd_data_i[g]), .rd_ready_i(mst_rd_ready_o[g]));
  end
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic cmp_word(input string n, input logic [PWW-1:0] e, input logic [PWW-1:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : cmp_word
  task automatic cmp_resp(input string n, input logic [1:0] e, input logic [1:0] g);
    cmp_word(n, PWW'(e), PWW'(g));
  endtask : cmp_resp
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  // Response code is {retry, claim}; zero means the cycle was ignored.
  task automatic txn(input int d, input logic [3:0] c, input logic [31:0] a, input logic h, output logic [1:0] s);
    @(negedge mclk_i);
    tgt_start_i[d] = 1'b1;
    tgt_cmd_i[d] = c;
    tgt_addr_i[d] = a;
    tgt_hit_i[d] = h;
    tgt_par_i[d] = ^{a, c};
    @(negedge mclk_i);
    tgt_start_i[d] = 1'b0;
    if (c == C_DAC) begin
      tgt_cmd_i[d] = C_MWR;
      tgt_addr_i[d] = ~a;
    end
    s = 2'h0;
    for (int n = 0; n < 4 && s == 2'h0; n++) begin
      @(posedge mclk_i);
      #1;
      s = {tgt_retry_o[d], tgt_devsel_o[d]};
    end
  endtask : txn
  task automatic post(input int d, input logic [3:0] c, input logic [31:0] a, input int n);
    int k = 0;
    int t = 0;
    txn(d, c, a, 1'b1, r);
    cmp_resp("claim", 2'h1, r);
    exp_q[d].push_back({1'b1, c, a});
    if (c == C_DAC) exp_q[d].push_back({1'b1, C_MWR, ~a});
    while (k < n && t < 8) begin
      @(negedge mclk_i);
      tgt_wvalid_i[d] = 1'b1;
      tgt_wdata_i[d] = rnd;
      tgt_be_i[d] = rnd[3:0];
      tgt_last_i[d] = (k == n - 1);
      #1;
      t++;
      if (tgt_wready_o[d]) begin
        exp_q[d].push_back({1'b0, rnd[3:0], rnd});
        k++;
        t = 0;
        rnd = lfsr(rnd);
        @(posedge mclk_i);
        #1;
        if (tgt_disc_o[d]) t = 8;
      end
    end
    @(negedge mclk_i);
    tgt_wvalid_i[d] = 1'b0;
    tgt_last_i[d] = 1'b0;
    cmp_word("words", PWW'((a[1:0] != LIN_BITS) ? 1 : n), PWW'(k));
  endtask : post
  task automatic drain(input int d);
    for (int t = 0; t < 300 && exp_q[d].size() != 0; t++) begin
      @(posedge mclk_i);
      #1;
      while (exp_q[d].size() != 0 && (d ? gp[1].p.pw_q.size() : gp[0].p.pw_q.size()) != 0)
        cmp_word("posted", exp_q[d].pop_front(), d ? gp[1].p.pw_q.pop_front() : gp[0].p.pw_q.pop_front());
    end
    cmp_word("left", '0, PWW'(exp_q[d].size()));
  endtask : drain
  task automatic dread(input int d, input logic [3:0] c, input logic [31:0] a);
    int k = 0;
    logic w = (c == C_IOWR || c == C_CFWR);
    logic [3:0] be = (c == C_MRM || c == C_MRL) ? BE_NONE : a[7:4];
    @(negedge mclk_i);
    tgt_wvalid_i[d] = w;
    tgt_wdata_i[d] = ~a;
    tgt_be_i[d] = a[7:4];
    tgt_type1_i[d] = (c == C_CFWR);
    txn(d, c, a, 1'b1, r);
    cmp_resp("queued", 2'h2, r);
    for (int t = 0; t < 200 && !mst_cpl_valid_i[d]; t++) begin
      @(posedge mclk_i);
      if (mst_dt_valid_o[d] && mst_dt_ready_i[d]) begin
        cmp_word("dtreq", {c == C_CFWR, be, ~a}, {mst_dt_type1_o[d], mst_dt_be_o[d], mst_dt_wdata_o[d]});
        cmp_resp("dtpar", {1'b0, ^{a, c}}, {mst_dt_dual_o[d], mst_dt_par_o[d]});
      end
    end
    txn(d, c, a, 1'b1, r);
    cmp_resp("rclaim", 2'h1, r);
    if (!w) begin
      for (int t = 0; t < 20 && k < 2; t++) begin
        @(negedge mclk_i);
        #1;
        if (tgt_rvalid_o[d]) begin
          cmp_word("rdata", PWW'(a + 32'(4 * k)), PWW'(tgt_rdata_o[d]));
          k++;
        end
      end
      @(posedge mclk_i);
      #1;
    end
    cmp_resp("done", 2'h1, {1'b0, tgt_done_o[d]});
    cmp_resp("status", a[5:4], tgt_status_o[d]);
    cmp_word("reads", PWW'(w ? 0 : 2), PWW'(k));
  endtask : dread
  initial begin
    repeat (30000) @(posedge mclk_i);
    fails++;
    complete_run();
  end
  initial begin
    {tgt_start_i, tgt_type1_i, tgt_hit_i, tgt_par_i, tgt_wvalid_i, tgt_last_i} = '0;
    {tgt_cmd_i, tgt_addr_i, tgt_be_i, tgt_wdata_i} = '0;
    tgt_rready_i = 2'h3;
    fails = 0;
    checks_done = 0;
    rnd = lfsr(32'h869b);
    reset_i = 1'b1;
    repeat (8) @(negedge mclk_i);
    reset_i = 1'b0;
    for (d = 0; d < 2; d++) begin
      foreach (bad[i]) begin
        txn(d, bad[i], rnd, 1'b1, r);
        cmp_resp("ignored", 2'h0, r);
      end
      txn(d, C_MWR, 32'h40, 1'b0, r);
      cmp_resp("nohit", 2'h0, r);
      post(d, C_MWR, {rnd[31:2], 2'h0}, 3);
      post(d, C_MWR, {rnd[31:2], 2'h1}, 3);
      post(d, C_DAC, {rnd[31:2], 2'h0}, 2);
      drain(d);
      dread(d, C_MRD, {rnd[31:2], 2'h0});
      dread(d, C_MRM, {rnd[30:2], 3'h0});
      dread(d, C_IOWR, {rnd[31:4], 4'h8});
      $display("test direction %0d done", d);
    end
    tgt_type1_i[1] = 1'b0;
    txn(1, C_CFRD, 32'h80, 1'b1, r);
    cmp_resp("cfgrd", 2'h0, r);
    txn(1, C_CFWR, 32'h84, 1'b1, r);
    cmp_resp("cfgwr0", 2'h0, r);
    dread(0, C_CFRD, 32'hB0);
    dread(1, C_CFWR, 32'h94);
    $display("test configuration done");
    complete_run();
  end
endmodule : testbench
